// [core/bss_pkg.sv]
package bss_pkg;

  // Configuration location of the secondary side status word
  localparam logic [7:0] SECONDARY_SIDE_STATUS_OFFSET = 8'h1e;
  localparam logic [5:0] SECONDARY_SIDE_STATUS_DWORD = 6'h07;
  localparam logic [15:0] SECONDARY_SIDE_STATUS_RESET = 16'h0280;

  // Field positions
  localparam int PARITY_ERROR_SEEN_BIT = 15;
  localparam int SYSTEM_ERROR_RECEIVED_BIT = 14;
  localparam int MASTER_ABORT_RECEIVED_BIT = 13;
  localparam int TARGET_ABORT_RECEIVED_BIT = 12;
  localparam int TARGET_ABORT_SIGNALED_BIT = 11;
  localparam int DEVSEL_TIMING_LSB = 9;
  localparam int DATA_PARITY_ERROR_BIT = 8;
  localparam int FAST_B2B_BIT = 7;
  localparam int USER_FEATURE_FLAG_BIT = 6;
  localparam int CAP_66MHZ_BIT = 5;

  // Fixed field values
  localparam logic [1:0] DEVSEL_TIMING_MEDIUM = 2'h1;
  localparam logic FAST_B2B_VALUE = 1'b1;

  // Pin index of the synchronised active-low PCI pins
  localparam int PIN_SYSTEM_ERROR = 0;
  localparam int PIN_PARITY_ERROR = 1;
  localparam int PIN_COUNT = 2;

  // Event strobes from the bridge datapath, one clock each
  typedef struct packed {
    logic bus_parity_error;      // Address or data parity error seen on PCI
    logic fwd_master_abort;      // Forwarded hub cycle master-aborted on PCI
    logic fwd_target_abort;      // Forwarded hub cycle target-aborted on PCI
    logic fwd_completion_req;    // Qualifies fwd_target_abort
    logic internal_read_perr;    // Internal parity error on a read
  } bss_events_t;

  // Qualifiers for the data parity flag
  typedef struct packed {
    logic parity_resp_enable;    // Bridge control bit 0 at offset 3Eh
    logic internal_master_owns;  // USB, audio or IDE master owns the cycle
    logic cycle_is_write;        // Current owned cycle is a write
  } bss_qual_t;

  // Configuration access from the hub side decoder
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] dword;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } bss_cfg_req_t;

endpackage

// [core/bss_secondary_status.sv]
// Notes on behaviour
// - Writing one to a clearable flag clears it; writing zero leaves it.
// - Bit 15 sets on PCI parity error in full variant; reads zero otherwise.
// - Bit 14 sets on received system error assertion, held until cleared.
// - Bit 13 sets when a forwarded hub cycle is master-aborted on PCI.
// - Bit 12 sets when a forwarded hub cycle is target-aborted on PCI.
// - Completion-required target abort returns abort to hub and flags primary status.
// - Bit 11 reads zero; never signal or forward target abort onto PCI.
// - Bits 10:9 report medium decode timing, read only.
// - Bit 8 sets when enabled, internal master owns, and write or read parity fails.
// - In reduced variant bit 8 reads zero whatever the bus does.
// - Bit 7 always reads one: fast back-to-back target capable.
// - Bits 6 and 5 read zero: no user features, no 66 MHz.
`timescale 1ns/1ps
`default_nettype none

module bss_secondary_status #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire bss_pkg::bss_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire bss_pkg::bss_events_t events,
  input wire bss_pkg::bss_qual_t qual,
  input wire logic serr_n_pin,
  input wire logic perr_n_pin,
  output logic hub_target_abort,
  output logic target_abort_signaled_set,
  output logic pci_target_abort,
  output logic [15:0] secondary_side_status
);
  import bss_pkg::*;

  // Pin synchroniser stages and the agreed level
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] sync1_q;
  logic [PIN_COUNT-1:0] sync2_q;
  logic [PIN_COUNT-1:0] sync3_q;
  logic [PIN_COUNT-1:0] level_n_q;
  logic [PIN_COUNT-1:0] level_n_d;

  // Sticky flags
  logic pe_seen_q, pe_seen_d;
  logic se_rcvd_q, se_rcvd_d;
  logic ma_rcvd_q, ma_rcvd_d;
  logic ta_rcvd_q, ta_rcvd_d;
  logic dpar_q, dpar_d;

  // Config answer and side outputs
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic hub_ta_q, hub_ta_d;
  logic sig_ta_q, sig_ta_d;

  logic hit;
  logic [15:0] wr_half;
  logic [15:0] clr_mask;
  logic serr_assert;
  logic perr_assert;
  logic [15:0] status_word;

  assign pin_raw[PIN_SYSTEM_ERROR] = serr_n_pin;
  assign pin_raw[PIN_PARITY_ERROR] = perr_n_pin;

  // Three-stage synchroniser per pin; stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      // Level moves only once the last two stages agree, filtering a glitch
      always_comb
      begin
        level_n_d[gi] = level_n_q[gi];
        if (sync2_q[gi] == sync3_q[gi])
        begin
          level_n_d[gi] = sync3_q[gi];
        end
      end

      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
          sync3_q[gi] <= 1'b1;
          level_n_q[gi] <= 1'b1;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          level_n_q[gi] <= level_n_d[gi];
        end
      end
    end
  endgenerate

  // Falling edge of the agreed level marks a new system error assertion
  assign serr_assert = level_n_q[PIN_SYSTEM_ERROR] & ~level_n_d[PIN_SYSTEM_ERROR];
  // Parity error pin is a level sampled during the owned write
  assign perr_assert = ~level_n_q[PIN_PARITY_ERROR];

  // Config decode: status sits in the upper half of its dword
  assign hit = (cfg_req.dword == SECONDARY_SIDE_STATUS_DWORD);
  assign wr_half = cfg_req.wdata[31:16];

  // Byte lanes 3 and 2 carry the status bytes
  always_comb
  begin
    clr_mask = 16'h0000;
    if (cfg_req.wr && hit)
    begin
      if (cfg_req.byte_en[3])
      begin
        clr_mask[15:8] = wr_half[15:8];
      end
      if (cfg_req.byte_en[2])
      begin
        clr_mask[7:0] = wr_half[7:0];
      end
    end
  end

  // Sticky flags: a new event wins over a same-cycle clear so none is lost
  always_comb
  begin
    pe_seen_d = pe_seen_q & ~clr_mask[PARITY_ERROR_SEEN_BIT];
    se_rcvd_d = se_rcvd_q & ~clr_mask[SYSTEM_ERROR_RECEIVED_BIT];
    ma_rcvd_d = ma_rcvd_q & ~clr_mask[MASTER_ABORT_RECEIVED_BIT];
    ta_rcvd_d = ta_rcvd_q & ~clr_mask[TARGET_ABORT_RECEIVED_BIT];
    dpar_d = dpar_q & ~clr_mask[DATA_PARITY_ERROR_BIT];
    if (FULL_VARIANT && events.bus_parity_error)
    begin
      pe_seen_d = 1'b1;
    end
    if (serr_assert)
    begin
      se_rcvd_d = 1'b1;
    end
    if (events.fwd_master_abort)
    begin
      ma_rcvd_d = 1'b1;
    end
    if (events.fwd_target_abort)
    begin
      ta_rcvd_d = 1'b1;
    end
    // Enable and ownership must both hold; cycle_is_write picks the pin or the read error
    if (FULL_VARIANT && qual.parity_resp_enable && qual.internal_master_owns &&
        ((qual.cycle_is_write && perr_assert) ||
         (!qual.cycle_is_write && events.internal_read_perr)))
    begin
      dpar_d = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pe_seen_q <= 1'b0;
      se_rcvd_q <= 1'b0;
      ma_rcvd_q <= 1'b0;
      ta_rcvd_q <= 1'b0;
      dpar_q <= 1'b0;
    end
    else
    begin
      pe_seen_q <= pe_seen_d;
      se_rcvd_q <= se_rcvd_d;
      ma_rcvd_q <= ma_rcvd_d;
      ta_rcvd_q <= ta_rcvd_d;
      dpar_q <= dpar_d;
    end
  end

  // Assemble the status word; variant gating keeps reduced parts at zero
  always_comb
  begin
    status_word = 16'h0000;
    status_word[PARITY_ERROR_SEEN_BIT] = FULL_VARIANT ? pe_seen_q : 1'b0;
    status_word[SYSTEM_ERROR_RECEIVED_BIT] = se_rcvd_q;
    status_word[MASTER_ABORT_RECEIVED_BIT] = ma_rcvd_q;
    status_word[TARGET_ABORT_RECEIVED_BIT] = ta_rcvd_q;
    status_word[TARGET_ABORT_SIGNALED_BIT] = 1'b0;
    status_word[DEVSEL_TIMING_LSB +: 2] = DEVSEL_TIMING_MEDIUM;
    status_word[DATA_PARITY_ERROR_BIT] = FULL_VARIANT ? dpar_q : 1'b0;
    status_word[FAST_B2B_BIT] = FAST_B2B_VALUE;
    status_word[USER_FEATURE_FLAG_BIT] = 1'b0;
    status_word[CAP_66MHZ_BIT] = 1'b0;
  end

  // Read answer one clock after the strobe; other offsets read zero
  always_comb
  begin
    ack_d = cfg_req.rd | cfg_req.wr;
    rdata_d = 32'h0000_0000;
    if (cfg_req.rd && hit)
    begin
      rdata_d = {status_word, 16'h0000};
    end
  end

  // Target abort on a completion-required cycle goes back to the hub
  always_comb
  begin
    hub_ta_d = events.fwd_target_abort & events.fwd_completion_req;
    sig_ta_d = events.fwd_target_abort & events.fwd_completion_req;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      hub_ta_q <= 1'b0;
      sig_ta_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      hub_ta_q <= hub_ta_d;
      sig_ta_q <= sig_ta_d;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_ack = ack_q;
  assign hub_target_abort = hub_ta_q;
  assign target_abort_signaled_set = sig_ta_q;
  // Bridge never raises or forwards a target abort toward PCI
  assign pci_target_abort = 1'b0;
  assign secondary_side_status = status_word;

endmodule

`default_nettype wire

// [tb/bss_secondary_status_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module bss_secondary_status_asserts #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire bss_pkg::bss_cfg_req_t cfg_req,
  input wire bss_pkg::bss_events_t events,
  input wire bss_pkg::bss_qual_t qual,
  input wire logic serr_n_pin,
  input wire logic hub_target_abort,
  input wire logic target_abort_signaled_set,
  input wire logic pci_target_abort,
  input wire logic [15:0] secondary_side_status
);
  import bss_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Write of one to bit 13 with no competing set
  sequence s_clr_ma;
    cfg_req.wr && cfg_req.dword == 6'h07 && cfg_req.byte_en[3] && cfg_req.wdata[29]
      && !events.fwd_master_abort;
  endsequence
  // Pin low for two samples beats the glitch filter
  sequence s_serr_fall;
    $fell(serr_n_pin) ##1 !serr_n_pin;
  endsequence
  chk_clear_one: assert property (s_clr_ma |=> !secondary_side_status[13])
    else $error("bit 13 not cleared");
  chk_serr_flag: assert property (s_serr_fall |-> ##[2:4] secondary_side_status[14])
    else $error("bit 14 not set by pin");
  chk_mabort_flag: assert property (events.fwd_master_abort |=> secondary_side_status[13])
    else $error("bit 13 not set");
  chk_tabort_hub: assert property (events.fwd_target_abort && events.fwd_completion_req
    |=> hub_target_abort && target_abort_signaled_set && secondary_side_status[12])
    else $error("target abort not reported");
  chk_parity_flag: assert property (FULL_VARIANT && events.bus_parity_error
    |=> secondary_side_status[15]) else $error("bit 15 not set");
  chk_read_perr: assert property (FULL_VARIANT && qual == 3'b110
    && events.internal_read_perr |=> secondary_side_status[8]) else $error("bit 8 not set");
  chk_reset_value: assert property ($rose(rst_n) |-> secondary_side_status == 16'h0280)
    else $error("bad reset value");
  chk_devsel_medium: assert property (secondary_side_status[10:9] == DEVSEL_TIMING_MEDIUM)
    else $error("bad decode timing");
  chk_fixed_bits: assert property (!pci_target_abort && !secondary_side_status[11]
    && secondary_side_status[7:0] == 8'h80) else $error("fixed bits wrong");
  chk_reduced_zero: assert property (!FULL_VARIANT |-> !secondary_side_status[15]
    && !secondary_side_status[8]) else $error("reduced variant flag set");
endmodule
bind bss_secondary_status bss_secondary_status_asserts #(.FULL_VARIANT(FULL_VARIANT)) i_chk (
  .clock, .rst_n, .cfg_req, .events, .qual, .serr_n_pin, .hub_target_abort,
  .target_abort_signaled_set, .pci_target_abort, .secondary_side_status);
`default_nettype wire

// [tb/bss_pci_agent.sv]
`timescale 1ns/1ps
`default_nettype none
module bss_pci_agent (
  input wire logic clock,
  input wire logic [3:0] serr_len,
  input wire logic [3:0] perr_len,
  output logic serr_n_pin,
  output logic perr_n_pin
);
  logic [3:0] s_q = 4'h0;
  logic [3:0] p_q = 4'h0;
  // Hold each pin low for the asked number of clocks
  always @(posedge clock)
  begin
    s_q <= (serr_len != 4'h0) ? serr_len : s_q - (s_q != 4'h0);
    p_q <= (perr_len != 4'h0) ? perr_len : p_q - (p_q != 4'h0);
  end
  // Released pins rise on their pull-ups
  assign serr_n_pin = (s_q == 4'h0);
  assign perr_n_pin = (p_q == 4'h0);
endmodule
`default_nettype wire

// [tb/bridge_secondary_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module bridge_secondary_status_tb;
  import bss_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  bss_cfg_req_t req = '0;
  bss_events_t ev = '0;
  bss_qual_t q = '0;
  logic [3:0] sl = 4'h0;
  logic [3:0] pl = 4'h0;
  logic serr_n, perr_n, ack;
  logic [31:0] rdata;
  logic [15:0] st = 16'h0280;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  logic [31:0] exp_v;
  logic [31:0] rdata_lite;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #4 clock = ~clock;
  bss_secondary_status i_dut (.clock(clock), .rst_n(rst_n), .cfg_req(req),
    .cfg_rdata(rdata), .cfg_ack(ack), .events(ev), .qual(q), .serr_n_pin(serr_n),
    .perr_n_pin(perr_n), .hub_target_abort(), .target_abort_signaled_set(),
    .pci_target_abort(), .secondary_side_status());
  // Reduced variant sees the same traffic; bits 15 and 8 must stay zero
  bss_secondary_status #(.FULL_VARIANT(1'b0)) i_dut_lite (.clock(clock), .rst_n(rst_n),
    .cfg_req(req), .cfg_rdata(rdata_lite), .cfg_ack(), .events(ev), .qual(q),
    .serr_n_pin(serr_n), .perr_n_pin(perr_n), .hub_target_abort(),
    .target_abort_signaled_set(), .pci_target_abort(), .secondary_side_status());
  bss_pci_agent i_agent (.clock(clock), .serr_len(sl), .perr_len(pl),
    .serr_n_pin(serr_n), .perr_n_pin(perr_n));
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One config access; writes and misses answer zero
  task automatic cfg(input logic wr, input logic [5:0] dw, input logic [3:0] be,
    input logic [31:0] wd, input logic [31:0] e);
    @(negedge clock);
    req = {~wr, wr, dw, be, wd};
    exp_q.push_back(e);
    @(negedge clock);
    req = '0;
  endtask
  task automatic pulse(input bss_events_t e);
    @(negedge clock);
    ev = e;
    @(negedge clock);
    ev = '0;
  endtask
  // Answers matched in request order, sampled mid-cycle once settled
  always @(negedge clock)
  begin
    if (ack === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        bad_count++;
        $display("ERROR cfg_ack expected 0 seen 1");
      end
      else
      begin
        exp_v = exp_q.pop_front();
        samples_checked++;
        if (rdata !== exp_v)
        begin
          bad_count++;
          $display("ERROR cfg_rdata expected %h seen %h", exp_v, rdata);
        end
        if (rdata_lite !== (exp_v & 32'h7EFF_FFFF))
        begin
          bad_count++;
          $display("ERROR lite cfg_rdata expected %h seen %h",
            exp_v & 32'h7EFF_FFFF, rdata_lite);
        end
      end
    end
  end
  // Hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  initial
  begin
    r = $urandom(73079);
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    cfg(1'b0, 6'h07, 4'h0, 32'h0, {st, 16'h0000});
    cfg(1'b0, 6'($urandom_range(6, 0)), 4'h0, 32'h0, 32'h0);
    cfg(1'b1, 6'h07, 4'h3, 32'hFFFF_FFFF, 32'h0);
    pulse(5'b11110);
    q = 3'b111;
    @(negedge clock);
    sl = 4'h6;
    pl = 4'h6;
    @(negedge clock);
    sl = 4'h0;
    pl = 4'h0;
    repeat (10) @(negedge clock);
    st = st | 16'hF100;
    cfg(1'b0, 6'h07, 4'h0, 32'h0, {st, 16'h0000});
    repeat (4)
    begin
      r = $urandom;
      cfg(1'b1, 6'h07, 4'hC, r, 32'h0);
      st = st & ~(r[31:16] & 16'hF100);
      cfg(1'b0, 6'h07, 4'h0, 32'h0, {st, 16'h0000});
    end
    q = 3'b110;
    pulse(5'b00001);
    st = st | 16'h0100;
    cfg(1'b0, 6'h07, 4'h0, 32'h0, {st, 16'h0000});
    cfg(1'b1, 6'h07, 4'hC, 32'hFFFF_0000, 32'h0);
    cfg(1'b0, 6'h07, 4'h0, 32'h0, 32'h0280_0000);
    // Event and clear in one cycle: the event must win
    fork
      cfg(1'b1, 6'h07, 4'hC, 32'h2000_0000, 32'h0);
      pulse(5'b01000);
    join
    cfg(1'b0, 6'h07, 4'h0, 32'h0, 32'h2280_0000);
    // Mid-run reset must drop the bit 15, 13 and 12 sticky flags that the pulse sets
    pulse(5'b11110);
    @(negedge clock);
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    cfg(1'b0, 6'h07, 4'h0, 32'h0, 32'h0280_0000);
    repeat (4) @(negedge clock);
    if (exp_q.size() != 0)
    begin
      bad_count++;
      $display("ERROR exp_q expected 0 seen %0d", exp_q.size());
    end
    print_verdict();
  end
endmodule
`default_nettype wire
